/* File: rtl/sel_loader.sv */
// Purpose: Serial configuration ROM loader and software access registers
// Assumes: Host register port on ref_clk; ROM data pin is asynchronous
// Notes: Loads words after reset, then serves unlocked software access
`timescale 1ns/1ps
// Functional notes
// - After every reset, read the stored ROM words out to the configuration registers.
// - Software reaches the ROM through registers of the controller register space.
// - Command and data registers open only after the two key words back to back.
// - Writing one to the retry bit re-runs the pending operation.
// - A finished read leaves the addressed ROM word in the data register.
// - Completion flag at bit 25 reads one when done; resets to one.
// - Error flag at bit 24 reads one when the last operation failed.
// - Write-only retry control at bit 24, reset zero, for a stuck operation.
// - Op code field bits 23:22, read-write, resets to 00.
// - Index field bits 21:16, read-write, resets to 00.
// - Data register holds the word to write and returns the word read.
// - Loaded configuration bit 4 enables the wake signal.
// - Loaded configuration bit 2 opens debug register access.
// - Loaded configuration bit 1 byte-swaps configuration ROM read data.
// - Loaded configuration bit 0 sets the option ROM enable.
module sel_loader #(
    parameter int LOAD_WORDS = sel_pkg::LOAD_WORDS,
    parameter logic [5:0] CFG_INDEX = sel_pkg::CFG_WORD_INDEX,
    parameter int SK_HALF = sel_pkg::SK_HALF_CYCLES,
    parameter int WR_TIMEOUT_CYCLES = sel_pkg::WR_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Host register port
    input wire logic [1:0] regSel,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // Serial ROM pins
    output logic romCs,
    output logic romSk,
    output logic romDi,
    input wire logic romDo,
    // Loaded word stream
    output logic loadWrEn,
    output logic [5:0] loadIndex,
    output logic [15:0] loadData,
    output logic loadDone,
    // Loaded configuration
    output logic wakeSignalEnable,
    output logic debugAccessEnable,
    output logic cfgRomByteSwap,
    output logic optionRomEnable
);
    typedef enum logic [2:0] {
        LD_ISSUE = 3'b001,
        LD_WAIT = 3'b010,
        SW_READY = 3'b100
    } sel_state_t;

    sel_state_t state_ff, nxt_state;
    logic [5:0] loadIdx_ff;
    logic doMeta_ff, doSync_ff;
    logic keyStage_ff, unlocked_ff;
    logic complete_ff, error_ff;
    logic [1:0] opCode_ff;
    logic [5:0] index_ff;
    logic [15:0] data_ff;
    logic pendStart_ff;
    logic [31:0] regRdData_ff;
    logic regRdValid_ff;
    logic loadWrEn_ff, loadDone_ff;
    logic [5:0] loadIndex_ff;
    logic [15:0] loadData_ff;
    logic wake_ff, debug_ff, swap_ff, optRom_ff;
    logic engDone, engErr;
    logic [15:0] engRd;

    // Register decode
    wire ready = state_ff == SW_READY;
    wire keyWr = regWrEn & (regSel == sel_pkg::REG_KEY);
    wire cmdWr = regWrEn & (regSel == sel_pkg::REG_CMD) & unlocked_ff;
    wire dataWr = regWrEn & (regSel == sel_pkg::REG_DATA) & unlocked_ff;
    wire [1:0] wrOp = regWrData[sel_pkg::CMD_OP_LSB+:2];
    wire [5:0] wrIndex = regWrData[sel_pkg::CMD_INDEX_LSB+:6];
    wire retryReq = cmdWr & regWrData[sel_pkg::CMD_RETRY_BIT];
    wire cmdLaunch = cmdWr & (retryReq | (wrOp != sel_pkg::OP_WRITE));
    wire dataLaunch = dataWr & (opCode_ff == sel_pkg::OP_WRITE);
    wire swLaunch = ready & (cmdLaunch | dataLaunch);
    wire swStart = ready & pendStart_ff;
    wire engStart = (state_ff == LD_ISSUE) | swStart;
    wire [1:0] engOp = ready ? opCode_ff : sel_pkg::OP_READ;
    wire [5:0] engIdx = ready ? index_ff : loadIdx_ff;
    wire swDone = ready & engDone;
    wire loadGot = (state_ff == LD_WAIT) & engDone;
    wire loadLast = loadIdx_ff == 6'(LOAD_WORDS - 1);
    wire keyOk = keyStage_ff & (regWrData == sel_pkg::KEY_SECOND);
    wire keyFirst = regWrData == sel_pkg::KEY_FIRST;
    wire [31:0] cmdView = {6'h00, complete_ff, error_ff, opCode_ff, index_ff, 16'h0000};
    wire [31:0] dataView = {16'h0000, data_ff};
    wire cmdRd = (regSel == sel_pkg::REG_CMD) & unlocked_ff;
    wire dataRd = (regSel == sel_pkg::REG_DATA) & unlocked_ff;
    wire [31:0] rdMux = cmdRd ? cmdView : dataRd ? dataView : 32'h0000_0000;

    // ROM data pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            doMeta_ff <= 1'b0;
            doSync_ff <= 1'b0;
        end else begin
            doMeta_ff <= romDo;
            doSync_ff <= doMeta_ff;
        end
    end

    // Load sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            LD_ISSUE: nxt_state = LD_WAIT;
            LD_WAIT: if (engDone) nxt_state = loadLast ? SW_READY : LD_ISSUE;
            SW_READY: nxt_state = SW_READY;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) state_ff <= LD_ISSUE;
        else state_ff <= nxt_state;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) loadIdx_ff <= 6'h00;
        else if (loadGot && !loadLast) loadIdx_ff <= loadIdx_ff + 6'h01;
    end

    // Loaded word stream
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            loadWrEn_ff <= 1'b0;
            loadDone_ff <= 1'b0;
            loadIndex_ff <= 6'h00;
            loadData_ff <= 16'h0000;
        end else begin
            loadWrEn_ff <= loadGot;
            if (loadGot && loadLast) loadDone_ff <= 1'b1;
            if (loadGot) loadIndex_ff <= loadIdx_ff;
            if (loadGot) loadData_ff <= engRd;
        end
    end

    // Configuration byte capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
            debug_ff <= 1'b0;
            swap_ff <= 1'b0;
            optRom_ff <= 1'b0;
        end else if (loadGot && loadIdx_ff == CFG_INDEX) begin
            wake_ff <= engRd[sel_pkg::CFG_WAKE_BIT];
            debug_ff <= engRd[sel_pkg::CFG_DEBUG_BIT];
            swap_ff <= engRd[sel_pkg::CFG_SWAP_BIT];
            optRom_ff <= engRd[sel_pkg::CFG_OPTROM_BIT];
        end
    end

    // Unlock key sequence
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            keyStage_ff <= 1'b0;
            unlocked_ff <= 1'b0;
        end else if (keyWr) begin
            unlocked_ff <= keyOk;
            keyStage_ff <= keyFirst;
        end
    end

    // Command fields
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            opCode_ff <= sel_pkg::OP_RESET;
            index_ff <= sel_pkg::INDEX_RESET;
        end else if (cmdWr && !retryReq) begin
            opCode_ff <= wrOp;
            index_ff <= wrIndex;
        end
    end

    // Launch one cycle after the register write so fields are settled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) pendStart_ff <= 1'b0;
        else pendStart_ff <= swLaunch;
    end

    // Status flags, completion set wins over a same-cycle launch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            complete_ff <= sel_pkg::COMPLETE_RESET;
            error_ff <= sel_pkg::ERROR_RESET;
        end else begin
            if (swDone) complete_ff <= 1'b1;
            else if (swStart) complete_ff <= 1'b0;
            if (swDone) error_ff <= engErr;
        end
    end

    // Data register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) data_ff <= sel_pkg::DATA_RESET;
        else if (swDone && opCode_ff == sel_pkg::OP_READ) data_ff <= engRd;
        else if (dataWr) data_ff <= regWrData[15:0];
    end

    // Register read port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdData_ff <= 32'h0000_0000;
            regRdValid_ff <= 1'b0;
        end else begin
            regRdValid_ff <= regRdEn;
            if (regRdEn) regRdData_ff <= rdMux;
        end
    end

    sel_uwire_engine #(
        .SK_HALF(SK_HALF),
        .TIMEOUT(WR_TIMEOUT_CYCLES)
    ) u_engine (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(engStart),
        .opCode(engOp),
        .index(engIdx),
        .wrData(data_ff),
        .done(engDone),
        .error(engErr),
        .rdData(engRd),
        .doIn(doSync_ff),
        .romCs(romCs),
        .romSk(romSk),
        .romDi(romDi)
    );

    assign regRdData = regRdData_ff;
    assign regRdValid = regRdValid_ff;
    assign loadWrEn = loadWrEn_ff;
    assign loadIndex = loadIndex_ff;
    assign loadData = loadData_ff;
    assign loadDone = loadDone_ff;
    assign wakeSignalEnable = wake_ff;
    assign debugAccessEnable = debug_ff;
    assign cfgRomByteSwap = swap_ff;
    assign optionRomEnable = optRom_ff;

    // Checks
    load_start_a: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> engStart && !ready)
        else $error("load did not start after reset");
    lock_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!unlocked_ff && regWrEn && regSel == sel_pkg::REG_CMD)
        |=> $stable(opCode_ff) && $stable(index_ff) && !pendStart_ff)
        else $error("locked command register changed");
    unlock_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (keyWr && keyStage_ff && regWrData == sel_pkg::KEY_SECOND) |=> unlocked_ff)
        else $error("key pair did not unlock");
    relock_key_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (keyWr && !keyOk) |=> !unlocked_ff ##1 (unlocked_ff || !pendStart_ff))
        else $error("stray key write left registers open");
    retry_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ready && retryReq) |=> engStart ##1 !complete_ff || engDone)
        else $error("retry did not relaunch");
    read_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (swDone && opCode_ff == sel_pkg::OP_READ) |=> data_ff == $past(engRd) && complete_ff)
        else $error("read word not in data register");
    complete_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (swStart && !engDone) |=> !complete_ff)
        else $error("completion not cleared on launch");
    cmd_view_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (regRdEn && cmdRd) |=> regRdValid && regRdData[25:16] ==
        $past({complete_ff, error_ff, opCode_ff, index_ff}))
        else $error("command read view wrong");
    cfg_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (loadWrEn && loadIndex == CFG_INDEX) |-> wakeSignalEnable == loadData[4] &&
        debugAccessEnable == loadData[2] && cfgRomByteSwap == loadData[1] &&
        optionRomEnable == loadData[0])
        else $error("configuration bits not taken from loaded byte");
endmodule

/* File: rtl/sel_pkg.sv */
// Purpose: Shared constants for the serial configuration ROM loader
// Assumes: 100 MHz ref_clk, three-wire serial ROM with 16-bit words
// Notes: Register selects, field positions, keys, opcodes and timing
package sel_pkg;
    // Register selects on the host register port
    localparam logic [1:0] REG_KEY = 2'h0;
    localparam logic [1:0] REG_CMD = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    // Unlock keys
    localparam logic [31:0] KEY_FIRST = 32'hAA55_9966;
    localparam logic [31:0] KEY_SECOND = 32'h6699_55AA;
    // Command register fields
    localparam int CMD_COMPLETE_BIT = 25;
    localparam int CMD_ERROR_BIT = 24;
    localparam int CMD_RETRY_BIT = 24;
    localparam int CMD_OP_LSB = 22;
    localparam int CMD_INDEX_LSB = 16;
    // Reset values
    localparam logic COMPLETE_RESET = 1'b1;
    localparam logic ERROR_RESET = 1'b0;
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [5:0] INDEX_RESET = 6'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    // Operation codes
    localparam logic [1:0] OP_MISC = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    // Loaded configuration byte
    localparam logic [5:0] CFG_WORD_INDEX = 6'h07;
    localparam int CFG_WAKE_BIT = 4;
    localparam int CFG_DEBUG_BIT = 2;
    localparam int CFG_SWAP_BIT = 1;
    localparam int CFG_OPTROM_BIT = 0;
    localparam int LOAD_WORDS = 8;
    // Serial frame layout
    localparam logic [4:0] HDR_BITS = 5'h09;
    localparam logic [4:0] FRAME_BITS = 5'h19;
    localparam logic [4:0] DUMMY_SLOT = 5'h08;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SK_HALF_NS = 500;
    localparam int SK_HALF_CYCLES = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_TIMEOUT_NS = 10000000;
    localparam int WR_TIMEOUT_CYCLES = WR_TIMEOUT_NS / CLK_PERIOD_NS;
endpackage

/* File: rtl/sel_uwire_engine.sv */
// Purpose: Serial ROM bit engine: one read, write, erase or mode frame
// Assumes: doIn synchronised to ref_clk; SK_HALF of 3 or more
// Notes: A start while busy aborts the frame in flight and begins anew
`timescale 1ns/1ps
module sel_uwire_engine #(
    parameter int SK_HALF = sel_pkg::SK_HALF_CYCLES,
    parameter int TIMEOUT = sel_pkg::WR_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Operation request
    input wire logic start,
    input wire logic [1:0] opCode,
    input wire logic [5:0] index,
    input wire logic [15:0] wrData,
    // Operation result
    output logic done,
    output logic error,
    output logic [15:0] rdData,
    // Serial pins
    input wire logic doIn,
    output logic romCs,
    output logic romSk,
    output logic romDi
);
    localparam int DW = $clog2(SK_HALF + 1);
    localparam int TW = $clog2(TIMEOUT + 1);
    typedef enum logic [3:0] {
        EN_IDLE = 4'b0001,
        EN_SHIFT = 4'b0010,
        EN_GAP = 4'b0100,
        EN_POLL = 4'b1000
    } sel_eng_state_t;

    sel_eng_state_t state_ff, nxt_state;
    logic [DW-1:0] divCnt_ff;
    logic [TW-1:0] pollCnt_ff;
    logic [4:0] bitCnt_ff;
    logic [24:0] frame_ff;
    logic [15:0] rdShift_ff;
    logic [1:0] op_ff;
    logic dummyBad_ff;

    wire tick = divCnt_ff == DW'(SK_HALF - 1);
    wire shifting = state_ff == EN_SHIFT;
    wire riseTick = shifting & tick & ~romSk;
    wire fallTick = shifting & tick & romSk;
    wire [4:0] frameLen = (op_ff == sel_pkg::OP_READ || op_ff == sel_pkg::OP_WRITE) ?
        sel_pkg::FRAME_BITS : sel_pkg::HDR_BITS;
    wire lastBit = fallTick & (bitCnt_ff == frameLen - 5'h01);
    wire needsPoll = op_ff == sel_pkg::OP_WRITE || op_ff == sel_pkg::OP_ERASE;
    wire gapEnd = (state_ff == EN_GAP) & tick;
    // Pin reads stale until the synchroniser has seen the select
    wire pollSettled = pollCnt_ff > TW'(1);
    wire pollHit = (state_ff == EN_POLL) & doIn & pollSettled;
    wire pollOut = (state_ff == EN_POLL) & ~doIn & (pollCnt_ff == TW'(TIMEOUT - 1));
    wire finish = (gapEnd & ~needsPoll) | pollHit | pollOut;

    // Frame sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            EN_IDLE: nxt_state = state_ff;
            EN_SHIFT: if (lastBit) nxt_state = EN_GAP;
            EN_GAP: if (gapEnd) nxt_state = needsPoll ? EN_POLL : EN_IDLE;
            EN_POLL: if (pollHit | pollOut) nxt_state = EN_IDLE;
        endcase
        if (start) nxt_state = EN_SHIFT;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) state_ff <= EN_IDLE;
        else state_ff <= nxt_state;
    end

    // Serial clock divider
    always_ff @(posedge ref_clk) begin
        if (!rst_n || start || tick || state_ff == EN_IDLE) divCnt_ff <= '0;
        else divCnt_ff <= divCnt_ff + DW'(1);
    end

    // Shifting
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_ff <= '0;
            bitCnt_ff <= 5'h00;
            op_ff <= sel_pkg::OP_RESET;
        end else if (start) begin
            frame_ff <= {1'b1, opCode, index, wrData};
            bitCnt_ff <= 5'h00;
            op_ff <= opCode;
        end else if (fallTick) begin
            frame_ff <= {frame_ff[23:0], 1'b0};
            bitCnt_ff <= bitCnt_ff + 5'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdShift_ff <= 16'h0000;
            dummyBad_ff <= 1'b0;
        end else if (start) begin
            dummyBad_ff <= 1'b0;
        end else if (fallTick) begin
            rdShift_ff <= {rdShift_ff[14:0], doIn};
            if (bitCnt_ff == sel_pkg::DUMMY_SLOT && op_ff == sel_pkg::OP_READ)
                dummyBad_ff <= doIn;
        end
    end

    // Ready polling after a program cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n || gapEnd) pollCnt_ff <= '0;
        else if (state_ff == EN_POLL) pollCnt_ff <= pollCnt_ff + TW'(1);
    end

    // Pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            romCs <= 1'b0;
            romSk <= 1'b0;
            romDi <= 1'b0;
        end else if (start) begin
            romCs <= 1'b1;
            romSk <= 1'b0;
            romDi <= 1'b1;
        end else begin
            if (lastBit || pollHit || pollOut) romCs <= 1'b0;
            else if (gapEnd && needsPoll) romCs <= 1'b1;
            if (riseTick) romSk <= 1'b1;
            else if (fallTick) romSk <= 1'b0;
            if (fallTick) romDi <= lastBit ? 1'b0 : frame_ff[23];
        end
    end

    // Result
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done <= 1'b0;
            error <= 1'b0;
            rdData <= 16'h0000;
        end else begin
            done <= finish & ~start;
            if (finish) error <= pollOut | (gapEnd & dummyBad_ff);
            if (gapEnd && op_ff == sel_pkg::OP_READ) rdData <= rdShift_ff;
        end
    end
endmodule

/* File: testbench/sel_rom_model.sv */
// Purpose: Behavioural serial ROM on the far side of the loader
// Assumes: Bits taken on romSk rise while romCs is high
// Notes: stuck and badDummy are bench knobs for failure cases
`timescale 1ns/1ps
module sel_rom_model #(
    parameter int BUSY = 20
) (
    input wire logic ref_clk,
    input wire logic romCs,
    input wire logic romSk,
    input wire logic romDi,
    output logic romDo
);
    logic [15:0] mem [64];
    logic [8:0] hdr = 9'h000;
    logic [15:0] sh = 16'h0000;
    logic dq = 1'b0;
    logic tog = 1'b0;
    logic wen = 1'b0;
    logic stuck = 1'b0;
    logic badDummy = 1'b0;
    logic busy = 1'b0;
    logic hang = 1'b0;
    int n = 0;
    int bc = 0;
    // Deselected output toggles, never holds the last bit
    always @(posedge ref_clk) tog <= ~tog;
    assign romDo = !romCs ? tog : (n == 0) ? !(busy || hang) : dq;
    always @(posedge romCs) n = 0;
    always @(posedge romSk) if (romCs) begin
        if (n < 9) hdr = {hdr[7:0], romDi};
        else sh = {sh[14:0], romDi};
        if (n == 8 && hdr[7:6] == 2'h2) dq <= #1 badDummy;
        else if (n > 8 && n < 25 && hdr[7:6] == 2'h2) dq <= #1 mem[hdr[5:0]][24 - n];
        n = n + 1;
    end
    always @(negedge romCs) begin
        if (n == 0) hang = 1'b0;
        else if (hdr[7:6] == 2'h0 && hdr[5:4] == 2'h3) wen = 1'b1;
        else if (hdr[7:6] == 2'h0 && hdr[5:4] == 2'h0) wen = 1'b0;
        else if (wen && hdr[7:6] != 2'h2 && hdr[7:6] != 2'h0) begin
            if (hdr[7:6] == 2'h3) sh = 16'hFFFF;
            if (stuck) hang = 1'b1;
            else busy = 1'b1;
        end
    end
    always @(posedge ref_clk) if (busy) begin
        bc <= bc + 1;
        if (bc == BUSY) begin
            mem[hdr[5:0]] <= sh;
            busy <= 1'b0;
            bc <= 0;
        end
    end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the serial ROM loader
// Assumes: Short serial and timeout parameters
// Notes: Register access through the plain host register port
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 0;
    logic rst_n = 0;
    logic regWrEn = 0;
    logic regRdEn = 0;
    logic [1:0] regSel = 0;
    logic [31:0] regWrData = 0;
    logic [31:0] regRdData, rv;
    logic regRdValid, romCs, romSk, romDi, romDo, loadWrEn, loadDone;
    logic [5:0] loadIndex;
    logic [15:0] loadData;
    logic wakeSignalEnable, debugAccessEnable, cfgRomByteSwap, optionRomEnable;
    logic [15:0] expMem [64];
    int n_mismatch = 0;
    int num_checks = 0;
    int ldCnt = 0;
    localparam logic [31:0] DN = 32'h0200_0000;
    localparam logic [31:0] ER = 32'h0100_0000;
    sel_loader #(.SK_HALF(4), .WR_TIMEOUT_CYCLES(64)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .regSel(regSel), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .romCs(romCs), .romSk(romSk), .romDi(romDi),
        .romDo(romDo), .loadWrEn(loadWrEn), .loadIndex(loadIndex), .loadData(loadData),
        .loadDone(loadDone), .wakeSignalEnable(wakeSignalEnable),
        .debugAccessEnable(debugAccessEnable), .cfgRomByteSwap(cfgRomByteSwap),
        .optionRomEnable(optionRomEnable));
    sel_rom_model i_rom (.ref_clk(ref_clk), .romCs(romCs), .romSk(romSk), .romDi(romDi),
        .romDo(romDo));
    initial forever #5 ref_clk = ~ref_clk;
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        regSel = s;
        regWrData = d;
        regWrEn = 1;
        @(posedge ref_clk);
        #1;
        regWrEn = 0;
    endtask
    task automatic rd(input logic [1:0] s);
        @(posedge ref_clk);
        #1;
        regSel = s;
        regRdEn = 1;
        @(posedge ref_clk);
        #1;
        regRdEn = 0;
        chk({31'h0, regRdValid}, 32'h0000_0001);
        rv = regRdData;
    endtask
    function automatic logic [31:0] c(input logic [1:0] o, input logic [5:0] x);
        return {8'h00, o, x, 16'h0000};
    endfunction
    // Poll the command word until complete, then compare it whole
    task automatic wait_cmd(input logic [31:0] exp);
        int i;
        rv = 0;
        repeat (2) @(posedge ref_clk);
        for (i = 0; i < 300 && rv[25] !== 1'b1; i++) rd(sel_pkg::REG_CMD);
        if (i == 300) begin
            n_mismatch++;
            end_of_test();
        end
        chk(rv, exp);
    endtask
    task automatic rdw(input logic [5:0] x);
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_READ, x));
        wait_cmd(DN | c(sel_pkg::OP_READ, x));
        rd(sel_pkg::REG_DATA);
        chk(rv, {16'h0000, expMem[x]});
    endtask
    task automatic reset_load(input logic [3:0] f);
        int i;
        rst_n = 0;
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1;
        for (i = 0; i < 3000 && loadDone !== 1'b1; i++) @(posedge ref_clk);
        if (i == 3000) begin
            n_mismatch++;
            end_of_test();
        end
        @(posedge ref_clk);
        #1;
        chk(ldCnt, sel_pkg::LOAD_WORDS);
        chk({28'h0, wakeSignalEnable, debugAccessEnable, cfgRomByteSwap, optionRomEnable}, f);
    endtask
    // Loaded word stream in order and content
    always @(posedge ref_clk) begin
        if (!rst_n) ldCnt <= 0;
        else if (loadWrEn) begin
            chk({26'h0, loadIndex}, ldCnt);
            chk({16'h0, loadData}, {16'h0, expMem[ldCnt]});
            ldCnt <= ldCnt + 1;
        end
    end
    initial begin
        #500000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        for (int i = 0; i < 64; i++) begin
            expMem[i] = 16'(i * 16'h0407) ^ 16'h96C3;
            i_rom.mem[i] = expMem[i];
        end
        expMem[7] = 16'h5A15;
        i_rom.mem[7] = 16'h5A15;
        reset_load(4'hD);
        wr(sel_pkg::REG_DATA, 32'h0000_1234);
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_READ, 6'h05));
        rd(sel_pkg::REG_CMD);
        chk(rv, 32'h0000_0000);
        rd(sel_pkg::REG_DATA);
        chk(rv, 32'h0000_0000);
        rd(2'h3);
        chk(rv, 32'h0000_0000);
        rd(sel_pkg::REG_KEY);
        chk(rv, 32'h0000_0000);
        wr(sel_pkg::REG_KEY, sel_pkg::KEY_FIRST);
        wr(sel_pkg::REG_KEY, 32'h1234_5678);
        wr(sel_pkg::REG_KEY, sel_pkg::KEY_SECOND);
        rd(sel_pkg::REG_CMD);
        chk(rv, 32'h0000_0000);
        wr(sel_pkg::REG_KEY, sel_pkg::KEY_FIRST);
        wr(sel_pkg::REG_KEY, sel_pkg::KEY_SECOND);
        rd(sel_pkg::REG_CMD);
        chk(rv, DN);
        rd(sel_pkg::REG_DATA);
        chk(rv, 32'h0000_0000);
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_MISC, 6'h30));
        wait_cmd(DN | c(sel_pkg::OP_MISC, 6'h30));
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_WRITE, 6'h07));
        wr(sel_pkg::REG_DATA, 32'h0000_C302);
        wait_cmd(DN | c(sel_pkg::OP_WRITE, 6'h07));
        expMem[7] = 16'hC302;
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_ERASE, 6'h0A));
        wait_cmd(DN | c(sel_pkg::OP_ERASE, 6'h0A));
        expMem[10] = 16'hFFFF;
        i_rom.stuck = 1;
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_WRITE, 6'h09));
        wr(sel_pkg::REG_DATA, 32'h0000_7E81);
        wait_cmd(DN | ER | c(sel_pkg::OP_WRITE, 6'h09));
        i_rom.stuck = 0;
        wr(sel_pkg::REG_CMD, ER);
        wait_cmd(DN | c(sel_pkg::OP_WRITE, 6'h09));
        expMem[9] = 16'h7E81;
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_MISC, 6'h00));
        wait_cmd(DN | c(sel_pkg::OP_MISC, 6'h00));
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_WRITE, 6'h08));
        wr(sel_pkg::REG_DATA, 32'h0000_BEEF);
        wait_cmd(DN | c(sel_pkg::OP_WRITE, 6'h08));
        i_rom.badDummy = 1;
        wr(sel_pkg::REG_CMD, c(sel_pkg::OP_READ, 6'h01));
        wait_cmd(DN | ER | c(sel_pkg::OP_READ, 6'h01));
        i_rom.badDummy = 0;
        foreach (expMem[i]) if (i < 11 || i == 63) rdw(6'(i));
        wr(sel_pkg::REG_KEY, 32'h0000_0000);
        rd(sel_pkg::REG_CMD);
        chk(rv, 32'h0000_0000);
        reset_load(4'h2);
        rd(sel_pkg::REG_CMD);
        chk(rv, 32'h0000_0000);
        end_of_test();
    end
endmodule
